// ==== tbi_defs.vh ====
`ifndef TBI_DEFS_VH
`define TBI_DEFS_VH

// register indexes on the bus; byte address is four times the index
`define TBI_ADDR_W          16
`define TBI_OFF_FDL_STAT    16'h0B70
`define TBI_OFF_FDL_EN      16'h0B71
`define TBI_OFF_SSM_STAT    16'h0B74
`define TBI_OFF_SSM_EN      16'h0B75
`define TBI_OFF_CI_STAT     16'h0B41
`define TBI_OFF_CI_EN       16'h0B42

// byte address is four times the index
`define TBI_BYTE_ADDR(idx)  ({(idx), 2'h0})

// fdl event bit positions
`define TBI_B_CODE_CHG      0
`define TBI_B_MATCH1        1
`define TBI_B_TX_EMPTY      2
`define TBI_B_RX_FULL       3
`define TBI_B_ABORT         4
`define TBI_B_CLEARED       5
`define TBI_B_MATCH2        6
`define TBI_B_MATCH3        7

// customer installation bits
`define TBI_B_RAI_CI        0
`define TBI_B_AIS_CI        1
`define TBI_B_RAI_ST        4
`define TBI_B_AIS_ST        5

// sync status message bit
`define TBI_B_SSM_UNST      6

`define TBI_RST_BYTE        8'h00
`define TBI_RST_WORD        32'h0000_0000
`define TBI_RST_SSM         6'h00
`define TBI_CI_EN_MASK      8'h03
`define TBI_SSM_EN_MASK     8'h40
`define TBI_CLR_COUNT       2'h3
`define TBI_AIS_PERIOD      386

`endif

// ==== tbi_flag_reg.v ====
`timescale 1ns/1ps
`default_nettype none

// sticky clear-on-read flag byte
module tbi_flag_reg #(
	parameter W = 8
) (
	input  wire         clk_i,
	input  wire         arst_n_i,
	input  wire [W-1:0] set_i,
	input  wire         rd_clr_i,
	output reg  [W-1:0] flag_o
);

	// set wins over read clear
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_o <= {W{1'h0}};
		end else begin
			flag_o <= (rd_clr_i ? {W{1'h0}} : flag_o) | set_i;
		end
	end

endmodule

`default_nettype wire

// ==== tbi_event_irq.v ====
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tbi_defs.vh"

module tbi_event_irq #(
	parameter SSM_W = 6
) (
	input  wire                    clk_i,
	input  wire                    arst_n_i,
	input  wire                    psel_i,
	input  wire                    penable_i,
	input  wire                    pwrite_i,
	input  wire [`TBI_ADDR_W+1:0]  paddr_i,
	input  wire [31:0]             pwdata_i,
	output wire                    pready_o,
	output reg  [31:0]             prdata_o,
	output wire                    pslverr_o,
	input  wire                    ais_ci_det_i,
	input  wire                    ais_ci_sig_ok_i,
	input  wire                    rai_ci_det_i,
	input  wire                    esf_mode_i,
	input  wire                    msg_valid_i,
	input  wire                    filter_ok_i,
	input  wire                    match_one_i,
	input  wire                    match_two_i,
	input  wire                    match_three_i,
	input  wire                    code_valid_i,
	input  wire                    code_framed_i,
	input  wire                    abort_ones_i,
	input  wire                    holding_full_i,
	input  wire                    tx_repeats_done_i,
	input  wire                    ssm_valid_i,
	input  wire [SSM_W-1:0]        ssm_code_i,
	output reg                     irq_o
);

	localparam ST_IDLE   = 2'h1;
	localparam ST_ACCESS = 2'h2;

	reg  [1:0]        state_q;
	reg  [1:0]        state_d;
	reg  [7:0]        fdl_en_q;
	reg  [7:0]        ci_en_q;
	reg  [7:0]        ssm_en_q;
	reg               ais_q;
	reg               rai_q;
	reg  [1:0]        nocode_cnt_q;
	reg  [SSM_W-1:0]  ssm_prev_q;
	reg               ssm_seen_q;
	reg               last_code_valid_q;
	wire [7:0]        fdl_flag;
	wire [7:0]        ci_flag;
	wire [7:0]        ssm_flag;
	wire [7:0]        fdl_set;
	wire [7:0]        ci_set;
	wire [7:0]        ssm_set;
	wire              rai_now;
	wire              ais_now;
	wire              access;
	wire              wr;
	wire              rd;
	wire              hit_fdl_s;
	wire              hit_fdl_e;
	wire              hit_ssm_s;
	wire              hit_ssm_e;
	wire              hit_ci_s;
	wire              hit_ci_e;
	wire              hit_any;
	wire              setup_rd;
	wire              ci_clr;
	wire              fdl_clr;
	wire              ssm_clr;
	wire              ci_en_wr;
	wire              fdl_en_wr;
	wire              ssm_en_wr;
	wire              irq_d;
	reg  [7:0]        rdata_d;

	function hit;
		input [`TBI_ADDR_W+1:0] a;
		input [`TBI_ADDR_W-1:0] idx;
		begin
			hit = (a == `TBI_BYTE_ADDR(idx));
		end
	endfunction

	// status view includes a set landing in setup
	function [7:0] stat_view;
		input [7:0] flag;
		input [7:0] ev;
		begin
			stat_view = flag | ev;
		end
	endfunction

	// any flag that is enabled
	function any_on;
		input [7:0] flag;
		input [7:0] en;
		begin
			any_on = |(flag & en);
		end
	endfunction

	// apb decode, zero wait states
	assign access    = psel_i & penable_i;
	assign wr        = access & pwrite_i;
	assign rd        = access & ~pwrite_i;
	assign pready_o  = (state_q == ST_ACCESS);
	assign hit_fdl_s = hit(paddr_i, `TBI_OFF_FDL_STAT);
	assign hit_fdl_e = hit(paddr_i, `TBI_OFF_FDL_EN);
	assign hit_ssm_s = hit(paddr_i, `TBI_OFF_SSM_STAT);
	assign hit_ssm_e = hit(paddr_i, `TBI_OFF_SSM_EN);
	assign hit_ci_s  = hit(paddr_i, `TBI_OFF_CI_STAT);
	assign hit_ci_e  = hit(paddr_i, `TBI_OFF_CI_EN);
	assign hit_any   = hit_fdl_s | hit_fdl_e | hit_ssm_s | hit_ssm_e | hit_ci_s | hit_ci_e;
	assign pslverr_o = pready_o & ~hit_any;

	// clear and write strobes act at the access edge
	assign setup_rd  = psel_i & ~penable_i & ~pwrite_i;
	assign ci_clr    = rd & hit_ci_s;
	assign fdl_clr   = rd & hit_fdl_s;
	assign ssm_clr   = rd & hit_ssm_s;
	assign ci_en_wr  = wr & hit_ci_e;
	assign fdl_en_wr = wr & hit_fdl_e;
	assign ssm_en_wr = wr & hit_ssm_e;

	always @* begin
		state_d = ST_IDLE;
		case (state_q)
			ST_IDLE: begin
				if (psel_i & ~penable_i) begin
					state_d = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign ais_now = ais_ci_det_i & ais_ci_sig_ok_i;
	assign rai_now = rai_ci_det_i & esf_mode_i;

	// ci level history for edge detection
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ais_q <= 1'h0;
			rai_q <= 1'h0;
		end else begin
			ais_q <= ais_now;
			rai_q <= rai_now;
		end
	end

	// non-code run length and last code state
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			nocode_cnt_q      <= 2'h0;
			last_code_valid_q <= 1'h0;
		end else if (msg_valid_i) begin
			last_code_valid_q <= code_valid_i;
			if (code_framed_i & ~code_valid_i) begin
				if (nocode_cnt_q != `TBI_CLR_COUNT) begin
					nocode_cnt_q <= nocode_cnt_q + 2'h1;
				end
			end else begin
				nocode_cnt_q <= 2'h0;
			end
		end
	end

	// last valid ssm and first-seen marker
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ssm_prev_q <= `TBI_RST_SSM;
			ssm_seen_q <= 1'h0;
		end else if (ssm_valid_i) begin
			ssm_prev_q <= ssm_code_i;
			ssm_seen_q <= 1'h1;
		end
	end

	assign ci_set[`TBI_B_AIS_CI] = ais_now ^ ais_q;
	assign ci_set[`TBI_B_RAI_CI] = rai_now ^ rai_q;
	assign ci_set[7:2] = 6'h00;

	assign fdl_set[`TBI_B_MATCH1]   = msg_valid_i & filter_ok_i & match_one_i;
	assign fdl_set[`TBI_B_MATCH2]   = msg_valid_i & filter_ok_i & match_two_i;
	assign fdl_set[`TBI_B_MATCH3]   = msg_valid_i & filter_ok_i & match_three_i;
	assign fdl_set[`TBI_B_CLEARED]  = msg_valid_i & code_framed_i & ~code_valid_i &
		(nocode_cnt_q == `TBI_CLR_COUNT - 2'h1);
	assign fdl_set[`TBI_B_ABORT]    = abort_ones_i;
	assign fdl_set[`TBI_B_RX_FULL]  = holding_full_i;
	assign fdl_set[`TBI_B_TX_EMPTY] = tx_repeats_done_i;
	assign fdl_set[`TBI_B_CODE_CHG] = msg_valid_i & filter_ok_i &
		(code_valid_i ^ last_code_valid_q);

	assign ssm_set[`TBI_B_SSM_UNST] = ssm_valid_i & ssm_seen_q & (ssm_code_i != ssm_prev_q);
	assign ssm_set[7]   = 1'h0;
	assign ssm_set[5:0] = 6'h00;

	tbi_flag_reg #(.W(8)) u_ci (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.set_i    (ci_set),
		.rd_clr_i (ci_clr),
		.flag_o   (ci_flag)
	);

	tbi_flag_reg #(.W(8)) u_fdl (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.set_i    (fdl_set),
		.rd_clr_i (fdl_clr),
		.flag_o   (fdl_flag)
	);

	tbi_flag_reg #(.W(8)) u_ssm (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.set_i    (ssm_set),
		.rd_clr_i (ssm_clr),
		.flag_o   (ssm_flag)
	);

	// enable registers
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fdl_en_q <= `TBI_RST_BYTE;
			ci_en_q  <= `TBI_RST_BYTE;
			ssm_en_q <= `TBI_RST_BYTE;
		end else begin
			if (fdl_en_wr) begin
				fdl_en_q <= pwdata_i[7:0];
			end
			if (ci_en_wr) begin
				ci_en_q <= pwdata_i[7:0] & `TBI_CI_EN_MASK;
			end
			if (ssm_en_wr) begin
				ssm_en_q <= pwdata_i[7:0] & `TBI_SSM_EN_MASK;
			end
		end
	end

	// read mux, one byte per word, unmapped reads zero
	always @* begin
		rdata_d = `TBI_RST_BYTE;
		if (hit_fdl_s) begin
			rdata_d = stat_view(fdl_flag, fdl_set);
		end
		if (hit_fdl_e) begin
			rdata_d = fdl_en_q;
		end
		if (hit_ssm_s) begin
			rdata_d = stat_view(ssm_flag, ssm_set);
		end
		if (hit_ssm_e) begin
			rdata_d = ssm_en_q;
		end
		if (hit_ci_s) begin
			rdata_d = stat_view(ci_flag, ci_set) & `TBI_CI_EN_MASK;
			rdata_d[`TBI_B_AIS_ST] = ais_now;
			rdata_d[`TBI_B_RAI_ST] = rai_now;
		end
		if (hit_ci_e) begin
			rdata_d = ci_en_q;
		end
	end

	// read data register, loaded in setup
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o <= `TBI_RST_WORD;
		end else if (setup_rd) begin
			prdata_o <= {24'h000000, rdata_d};
		end
	end

	assign irq_d = any_on(fdl_flag, fdl_en_q) | any_on(ci_flag, ci_en_q) |
		any_on(ssm_flag, ssm_en_q);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 1'h0;
		end else begin
			irq_o <= irq_d;
		end
	end

endmodule

`default_nettype wire

// ==== tbi_addrs.svh ====
localparam logic [17:0] A_FS = `TBI_BYTE_ADDR(`TBI_OFF_FDL_STAT);
localparam logic [17:0] A_FE = `TBI_BYTE_ADDR(`TBI_OFF_FDL_EN);
localparam logic [17:0] A_SS = `TBI_BYTE_ADDR(`TBI_OFF_SSM_STAT);
localparam logic [17:0] A_SE = `TBI_BYTE_ADDR(`TBI_OFF_SSM_EN);
localparam logic [17:0] A_CS = `TBI_BYTE_ADDR(`TBI_OFF_CI_STAT);
localparam logic [17:0] A_CE = `TBI_BYTE_ADDR(`TBI_OFF_CI_EN);

// ==== tbi_event_irq_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tbi_defs.vh"

module tbi_irq_chk (
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [17:0] paddr_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	input wire logic        irq_o
);
	`include "tbi_addrs.svh"
	logic hit;
	logic rd;
	logic xfer;
	assign hit = paddr_i inside {A_FS, A_FE, A_SS, A_SE, A_CS, A_CE};
	assign rd = pready_o && !pwrite_i;
	assign xfer = psel_i && penable_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	chk_ready_access: assert property (pready_o == xfer)
		else $error("ready off access");
	chk_err_unmapped: assert property (pslverr_o |-> pready_o && !hit)
		else $error("bad error");
	chk_mapped_ok: assert property (pready_o && hit |-> !pslverr_o)
		else $error("error on mapped");
	chk_rd_upper: assert property (rd |-> prdata_o[31:8] == 24'h000000)
		else $error("upper bits set");
	chk_unmapped_zero: assert property (rd && !hit |-> prdata_o == 32'h00000000)
		else $error("unmapped not zero");
	chk_ssm_reserved:
		assert property (rd && paddr_i == A_SS |-> prdata_o[5:0] == 6'h00 && !prdata_o[7])
		else $error("reserved set");
	chk_ci_en_mask:
		assert property (rd && paddr_i == A_CE |-> prdata_o[7:2] == 6'h00)
		else $error("ci enable mask");
	chk_ssm_en_mask:
		assert property (rd && paddr_i == A_SE |-> prdata_o[5:0] == 6'h00 && !prdata_o[7])
		else $error("ssm enable mask");
	chk_irq_fall:
		assert property ($fell(irq_o) |-> $past(xfer) || $past(xfer, 2))
		else $error("irq fell alone");
	cov_irq: cover property ($rose(irq_o));
	cov_err: cover property (pslverr_o);
	cov_rd_set: cover property (rd && prdata_o != 32'h00000000);
endmodule

bind tbi_event_irq tbi_irq_chk tbi_irq_chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb_t1_ci_boc_event_interrupts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tbi_defs.vh"

module tb_t1_ci_boc_event_interrupts;
	`include "tbi_addrs.svh"
	logic        clk_i = 1'h0;
	logic        arst_n_i = 1'h0;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic        rdy;
	logic        err;
	logic        irq;
	logic [17:0] pa = 18'h00000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic [3:0]  lv = 4'h0;
	logic [10:0] pv = 11'h000;
	logic [5:0]  sc = 6'h00;
	logic [17:0] adr [6] = '{A_FS, A_FE, A_SS, A_SE, A_CS, A_CE};
	int          num_errors = 0;
	int          num_checks = 0;

	tbi_event_irq tbi_event_irq_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pready_o(rdy),
		.prdata_o(prd), .pslverr_o(err), .ais_ci_det_i(lv[0]), .ais_ci_sig_ok_i(lv[1]),
		.rai_ci_det_i(lv[2]), .esf_mode_i(lv[3]), .msg_valid_i(pv[0]), .filter_ok_i(pv[1]),
		.match_one_i(pv[2]), .match_two_i(pv[3]), .match_three_i(pv[4]),
		.code_valid_i(pv[5]), .code_framed_i(pv[6]), .abort_ones_i(pv[7]),
		.holding_full_i(pv[8]), .tx_repeats_done_i(pv[9]), .ssm_valid_i(pv[10]),
		.ssm_code_i(sc), .irq_o(irq));

	initial forever #5 clk_i = ~clk_i;

	task automatic print_verdict();
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			num_errors++;
			$display("mismatch %0t got %h want %h", $time, g, x);
		end
	endtask

	// read compares d, write sends d
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic xe);
		int n;
		n = 0;
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (rdy !== 1'h1 && n < 20);
		chk({31'h0, rdy}, 32'h1);
		if (!w)
			chk(prd, d);
		chk({31'h0, err}, {31'h0, xe});
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic pl(input logic [10:0] v);
		pv <= v;
		@(posedge clk_i);
		pv <= 11'h000;
		@(posedge clk_i);
	endtask

	task automatic pf(input logic [10:0] v, input logic [31:0] x);
		pl(v);
		apb(1'h0, A_FS, x, 1'h0);
	endtask

	task automatic cl(input logic [3:0] v, input logic [31:0] x);
		lv <= v;
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		apb(1'h0, A_CS, x, 1'h0);
	endtask

	task automatic t_reset();
		foreach (adr[i]) apb(1'h0, adr[i], 32'h0, 1'h0);
		apb(1'h0, 18'h00004, 32'h0, 1'h1);
	endtask

	task automatic t_fdl();
		pf(11'h080, 32'h10);
		apb(1'h0, A_FS, 32'h0, 1'h0);
		pf(11'h100, 32'h08);
		pf(11'h200, 32'h04);
		pf(11'h013, 32'h80);
		pf(11'h00B, 32'h40);
		pf(11'h007, 32'h02);
		pf(11'h005, 32'h00);
		pf(11'h043, 32'h00);
		pf(11'h043, 32'h00);
		pf(11'h043, 32'h20);
		pf(11'h023, 32'h01);
		pf(11'h001, 32'h00);
	endtask

	task automatic t_ci();
		cl(4'h1, 32'h00);
		cl(4'h3, 32'h22);
		apb(1'h0, A_CS, 32'h20, 1'h0);
		cl(4'h0, 32'h02);
		cl(4'h4, 32'h00);
		cl(4'hC, 32'h11);
		cl(4'h8, 32'h01);
	endtask

	task automatic t_ssm();
		sc <= 6'h15;
		pl(11'h400);
		apb(1'h0, A_SS, 32'h0, 1'h0);
		pl(11'h400);
		apb(1'h0, A_SS, 32'h0, 1'h0);
		sc <= 6'h2A;
		pl(11'h400);
		apb(1'h0, A_SS, 32'h40, 1'h0);
		apb(1'h0, A_SS, 32'h0, 1'h0);
	endtask

	task automatic t_irq();
		apb(1'h1, A_FE, 32'hA5, 1'h0);
		apb(1'h0, A_FE, 32'hA5, 1'h0);
		apb(1'h1, A_FS, 32'hFF, 1'h0);
		apb(1'h0, A_FS, 32'h0, 1'h0);
		apb(1'h1, A_CE, 32'hFF, 1'h0);
		apb(1'h0, A_CE, 32'h03, 1'h0);
		apb(1'h1, A_SE, 32'hFF, 1'h0);
		apb(1'h0, A_SE, 32'h40, 1'h0);
		pl(11'h100);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		pl(11'h200);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		apb(1'h0, A_FS, 32'h0C, 1'h0);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		sc <= 6'h3F;
		pl(11'h400);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		apb(1'h1, A_SE, 32'h0, 1'h0);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		apb(1'h0, A_SS, 32'h40, 1'h0);
		lv <= 4'hB;
		repeat (4) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'h1;
		@(posedge clk_i);
		t_reset();
		t_fdl();
		t_ci();
		t_ssm();
		t_irq();
		print_verdict();
	end
endmodule
`default_nettype wire
